/* fsac_pkg.sv */
// Constants, field layouts and carrier types of the fault status and
// fault address capture block.
// Assumes an APB slave decode at byte offsets within the control space.
//
// Behaviour
// RL1 - The vector-read fault flag at bit 1 is set by a bus fault on a vector table fetch and reads 0 otherwise.
// RL2 - A vector-fetch bus fault is always sent to the hard fault handler, never to a configurable one.
// RL3 - With the vector-read flag set, the stacked return address is the preempted instruction.
// RL4 - The hard-fault status flags clear only when software writes 1 to them; writing 0 leaves them.
// RL5 - Reserved bits 29:2 and bit 0 of the hard-fault status read as zero.
// RL6 - The fault address registers at 0xD34 and 0xD38 refuse unprivileged access.
// RL7 - The memory-management fault address register captures the faulting location's address.
// RL8 - For an unaligned memory-management fault the exact faulting address is captured.
// RL9 - For split accesses the captured address may be any address within the requested span.
// RL10 - The memory-management fault address is meaningful only while its valid flag is set.
// RL11 - The bus fault address register captures the address the instruction requested.
// RL12 - The bus fault address is meaningful only while its valid flag is set.
// RL13 - The escalated-fault flag at bit 30 is set when a fault escalates to hard fault.
// RL14 - Each address register loads in the cycle its valid flag sets and holds until the next fault or write.
`default_nettype none

package fsac_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] FSAC_HFSR_OFF = 12'h0d2c;
    localparam logic [11:0] FSAC_MMFAR_OFF = 12'h0d34;
    localparam logic [11:0] FSAC_BFAR_OFF = 12'h0d38;
    localparam logic [11:0] FSAC_VALID_OFF = 12'h0d3c;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int FSAC_VECT_BIT = 1;
    localparam int FSAC_FORCED_BIT = 30;
    localparam int FSAC_MMV_BIT = 0;
    localparam int FSAC_BFV_BIT = 1;
    localparam logic [31:0] FSAC_ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] FSAC_ZERO = 32'h0000_0000;

    // Fault report from the detection logic in the core
    typedef struct packed {
        logic vect_bus_fault;
        logic escalated;
        logic mm_fault;
        logic [31:0] mm_addr;
        logic bus_fault;
        logic [31:0] bus_req_addr;
    } fsac_fault_s;

    // Whole state of the block
    typedef struct packed {
        logic vect_r;
        logic forced_r;
        logic mm_valid_r;
        logic bus_valid_r;
        logic [31:0] mm_addr_r;
        logic [31:0] bus_addr_r;
        logic [31:0] prdata_r;
        logic pslverr_r;
    } fsac_state_s;

endpackage : fsac_pkg

`default_nettype wire

/* fsac_fault_capture.sv */
// Fault status flags and fault address capture registers, APB slave.
// Assumes the core reports faults as one-cycle pulses on pclk and
// drives pprot[0] high for privileged accesses.
//
// The implementer's own choice: the APB slave port.
`default_nettype none

module fsac_fault_capture
    import fsac_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fault reports from the core
    input wire fsac_fault_s fault_i,
    // Routing and status towards the core
    output logic route_hard_fault,
    output logic stack_preempted_pc,
    output logic memmanage_address_valid,
    output logic bus_address_valid
);

    // ****************************************
    // State
    // ****************************************
    fsac_state_s st_r;
    fsac_state_s st_nxt;

    logic acc;
    logic wr;
    logic priv;
    logic addr_reg;
    logic known;
    logic [31:0] wmask;
    logic [31:0] rd;

    // Access decode; slave always answers in the access cycle
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign priv = pprot[0];
    assign addr_reg = (paddr == FSAC_MMFAR_OFF) || (paddr == FSAC_BFAR_OFF);
    assign known = addr_reg || (paddr == FSAC_HFSR_OFF)
        || (paddr == FSAC_VALID_OFF);

    // Byte enables widened to a bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{pstrb[i]}};
        end
    end

    // Read mux; reserved status bits stay zero
    always_comb begin
        rd = FSAC_ZERO; // RL5
        case (paddr)
            FSAC_HFSR_OFF: begin
                rd[FSAC_VECT_BIT] = st_r.vect_r;
                rd[FSAC_FORCED_BIT] = st_r.forced_r;
            end
            FSAC_MMFAR_OFF: rd = st_r.mm_addr_r;
            FSAC_BFAR_OFF: rd = st_r.bus_addr_r;
            FSAC_VALID_OFF: begin
                rd[FSAC_MMV_BIT] = st_r.mm_valid_r;
                rd[FSAC_BFV_BIT] = st_r.bus_valid_r;
            end
            default: rd = FSAC_ZERO;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    // Hardware sets win over software clears in the same cycle.
    // Read data and error are captured in the setup cycle so that both
    // come from flip-flops and already stand at the access edge; the
    // trade-off is that a fault landing in the setup cycle shows up on
    // the next read only.
    always_comb begin
        st_nxt = st_r;
        if (psel && !penable) begin
            st_nxt.pslverr_r = !known || (addr_reg && !priv); // RL6
            if (!pwrite && known && !(addr_reg && !priv)) begin
                st_nxt.prdata_r = rd;
            end else begin
                st_nxt.prdata_r = FSAC_ZERO;
            end
        end
        if (wr && priv) begin
            case (paddr)
                FSAC_HFSR_OFF: begin
                    // Write one to clear, zero leaves the flag
                    if (pstrb[0] && pwdata[FSAC_VECT_BIT]) begin
                        st_nxt.vect_r = 1'b0; // RL4
                    end
                    if (pstrb[3] && pwdata[FSAC_FORCED_BIT]) begin
                        st_nxt.forced_r = 1'b0; // RL4
                    end
                end
                FSAC_MMFAR_OFF: st_nxt.mm_addr_r =
                    (st_r.mm_addr_r & ~wmask) | (pwdata & wmask);
                FSAC_BFAR_OFF: st_nxt.bus_addr_r =
                    (st_r.bus_addr_r & ~wmask) | (pwdata & wmask);
                FSAC_VALID_OFF: begin
                    // Valid flags also clear by writing one
                    if (pstrb[0] && pwdata[FSAC_MMV_BIT]) begin
                        st_nxt.mm_valid_r = 1'b0; // RL10
                    end
                    if (pstrb[0] && pwdata[FSAC_BFV_BIT]) begin
                        st_nxt.bus_valid_r = 1'b0; // RL12
                    end
                end
                default: st_nxt.prdata_r = st_nxt.prdata_r;
            endcase
        end
        if (fault_i.vect_bus_fault) begin
            st_nxt.vect_r = 1'b1; // RL1
        end
        if (fault_i.escalated) begin
            st_nxt.forced_r = 1'b1; // RL13
        end
        // Address loads in the same cycle as its valid flag
        if (fault_i.mm_fault) begin
            st_nxt.mm_addr_r = fault_i.mm_addr; // RL7 RL8 RL9 RL14
            st_nxt.mm_valid_r = 1'b1; // RL10
        end
        if (fault_i.bus_fault) begin
            st_nxt.bus_addr_r = fault_i.bus_req_addr; // RL11 RL14
            st_nxt.bus_valid_r = 1'b1; // RL12
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{vect_r: 1'b0, forced_r: 1'b0, mm_valid_r: 1'b0,
                bus_valid_r: 1'b0, mm_addr_r: FSAC_ADDR_RST,
                bus_addr_r: FSAC_ADDR_RST, prdata_r: FSAC_ZERO,
                pslverr_r: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign pready = 1'b1;
    assign prdata = st_r.prdata_r;
    assign pslverr = acc && st_r.pslverr_r; // RL6
    // Vector fetch faults never go to a configurable handler
    assign route_hard_fault = fault_i.vect_bus_fault
        || fault_i.escalated; // RL2
    assign stack_preempted_pc = st_r.vect_r; // RL3
    assign memmanage_address_valid = st_r.mm_valid_r; // RL10
    assign bus_address_valid = st_r.bus_valid_r; // RL12

endmodule : fsac_fault_capture

`default_nettype wire

/* fsac_fault_capture_chk.sv */
// Port checker for the fault capture block.
// Bound into every instance; ports match by name.
`default_nettype none
module fsac_chk import fsac_pkg::*; (
    input wire logic pclk, presetn, psel, penable, pwrite, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [2:0] pprot,
    input wire logic [31:0] prdata,
    input wire fsac_fault_s fault_i,
    input wire logic route_hard_fault, stack_preempted_pc,
    input wire logic memmanage_address_valid, bus_address_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Routing is combinational, flags land one edge later
    a_vect_route: assert property (
        fault_i.vect_bus_fault |-> route_hard_fault) else $error("route");
    a_esc_route: assert property (
        fault_i.escalated |-> route_hard_fault) else $error("esc");
    a_vect_flag: assert property (
        fault_i.vect_bus_fault |=> stack_preempted_pc) else $error("flag");
    a_mm_load: assert property (
        fault_i.mm_fault |=> memmanage_address_valid) else $error("mm");
    a_bus_load: assert property (
        fault_i.bus_fault |=> bus_address_valid) else $error("bus");
    a_flag_hold: assert property (
        stack_preempted_pc && !(psel && penable && pwrite)
        |=> stack_preempted_pc) else $error("hold");
    a_priv_only: assert property (
        psel && penable && !pprot[0] && paddr inside {12'hd34, 12'hd38}
        |-> pslverr ##1 prdata == 32'h0) else $error("priv");
    a_rsvd_zero: assert property (
        psel && penable && !pwrite && paddr == 12'hd2c
        |=> prdata[29:2] == 28'h0 && !prdata[0]) else $error("rsvd");
    c_mm: cover property (fault_i.mm_fault);
    c_err: cover property (pslverr);
    c_clr: cover property (stack_preempted_pc ##1 !stack_preempted_pc);
endmodule // fsac_chk
bind fsac_fault_capture fsac_chk u_chk (.*);
`default_nettype wire

/* fsac_fault_capture_bench.sv */
// Bench: APB calls and fault pulses with expected values.
// Assumes fsac_chk is compiled alongside and binds itself.
`default_nettype none
module fsac_fault_capture_bench import fsac_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pv = 1'h1, pready, pslverr, route_hard_fault;
    logic stack_preempted_pc, memmanage_address_valid, bus_address_valid;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [32:0] rd;
    logic [2:0] pprot = 3'h1;
    fsac_fault_s fault_i = '0;
    int failures = 0, tests_run = 0;
    fsac_fault_capture dut (.*, .pstrb(4'hf));
    // 125 MHz clock, and a hang guard well past the run
    initial forever #4 pclk = ~pclk;
    initial begin
        repeat (3000) @(posedge pclk);
        failures++;
        stop_test();
    end
    // Error flag and data as one value
    task automatic chk(input logic [32:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Error and read data are both taken at the edge where pready is high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata, pprot} <= {1'h1, w, a, d, 2'h0, pv};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = {pslverr, prdata};
        {psel, penable} <= 2'h0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [32:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask
    // One-cycle pulse: k is {vector, escalated, mm, bus}
    task automatic flt(input logic [3:0] k, input logic [31:0] ma, ba);
        @(posedge pclk);
        fault_i <= {k[3], k[2], k[1], ma, k[0], ba};
        @(posedge pclk);
        fault_i <= '0;
    endtask
    task automatic stop_test();
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        rdc(12'hd3c, 33'h0);
        flt(4'h8, 32'h0, 32'h0);
        rdc(12'hd2c, 33'h2);
        apb(1'h1, 12'hd2c, 32'h0);
        rdc(12'hd2c, 33'h2);
        apb(1'h1, 12'hd2c, 32'hffff_ffff);
        flt(4'h4, 32'h0, 32'h0);
        rdc(12'hd2c, 33'h4000_0000);
        $display("test 1 done");
        flt(4'h3, 32'h2000_0003, 32'h4000_1001);
        rdc(12'hd34, 33'h2000_0003);
        rdc(12'hd38, 33'h4000_1001);
        rdc(12'hd3c, 33'h3);
        $display("test 2 done");
        pv = 1'h0;
        rdc(12'hd34, 33'h1_0000_0000);
        apb(1'h1, 12'hd38, 32'h0);
        pv = 1'h1;
        rdc(12'hd38, 33'h4000_1001);
        $display("test 3 done");
        stop_test();
    end
endmodule // fsac_fault_capture_bench
`default_nettype wire
